// ==== tec8_pkg.sv ====
package tec8_pkg;

	// ------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------
	localparam logic [15:0] ADDR_COUNT = 16'hff16;
	localparam logic [15:0] ADDR_MATCH = 16'hff17;
	localparam logic [15:0] ADDR_PORT_LATCH = 16'hff01;
	localparam logic [15:0] ADDR_PORT_DIR = 16'hff21;
	localparam logic [15:0] ADDR_SOURCE = 16'hff6a;
	localparam logic [15:0] ADDR_MODE = 16'hff6b;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int MODE_RUN_BIT = 7;
	localparam int MODE_PWM_BIT = 6;
	localparam int MODE_SET_BIT = 3;
	localparam int MODE_CLR_BIT = 2;
	localparam int MODE_TOG_BIT = 1;
	localparam int MODE_ALLOW_BIT = 0;
	localparam int PIN_DIR_BIT = 7;
	localparam int SOURCE_WIDTH = 3;
	localparam int PRESCALE_WIDTH = 13;

	// ------------------------------------------------------------
	// Count source codes and divider masks
	// ------------------------------------------------------------
	localparam logic [2:0] SRC_EV_FALL = 3'h0;
	localparam logic [2:0] SRC_EV_RISE = 3'h1;
	localparam logic [2:0] SRC_DIV1 = 3'h2;
	localparam logic [2:0] SRC_DIV2 = 3'h3;
	localparam logic [2:0] SRC_DIV4 = 3'h4;
	localparam logic [2:0] SRC_DIV64 = 3'h5;
	localparam logic [2:0] SRC_DIV256 = 3'h6;
	localparam logic [2:0] SRC_DIV8192 = 3'h7;
	localparam logic [12:0] MASK_DIV2 = 13'h0001;
	localparam logic [12:0] MASK_DIV4 = 13'h0003;
	localparam logic [12:0] MASK_DIV64 = 13'h003f;
	localparam logic [12:0] MASK_DIV256 = 13'h00ff;
	localparam logic [12:0] MASK_DIV8192 = 13'h1fff;

	// ------------------------------------------------------------
	// Values
	// ------------------------------------------------------------
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [7:0] COUNT_TOP = 8'hff;
	localparam logic [7:0] COUNT_STEP = 8'h01;
	localparam logic [12:0] PRESCALE_STEP = 13'h0001;
	localparam logic [7:0] PORT_DIR_RESET = 8'hff;
	localparam logic [1:0] SETCLR_SET = 2'h2;
	localparam logic [1:0] SETCLR_CLEAR = 2'h1;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic run;
		logic pwm;
		logic tog_pol;
		logic allow;
	} mode_type;

	typedef struct packed {
		logic meta;
		logic sync;
		logic prev;
	} event_sync_type;

	typedef struct packed {
		mode_type mode;
		logic [2:0] src;
		logic [7:0] count;
		logic [7:0] match;
		logic [7:0] pwm_cmp;
		logic [7:0] port_dir;
		logic [7:0] port_latch;
		logic [12:0] pre;
		event_sync_type ev;
		logic out_ff;
		logic pwm_level;
		logic irq;
		logic pin;
		logic oe;
		logic [7:0] rdata;
	} state_type;

	localparam state_type STATE_RESET = '{port_dir: PORT_DIR_RESET, default: '0};

endpackage

// ==== timer_event_counter_8bit.sv ====
`timescale 1ns/100ps

// What this block does
// - Count register steps up once per selected count clock; software only reads it.
// - Count clears on reset, when run is written zero, and on match in clear mode.
// - Outside PWM, count equal to compare value raises the match interrupt.
// - PWM output goes active at overflow unless compare is zero, inactive when count equals compare value.
// - Compare register holds any eight-bit value, read-write, resets to zero.
// - Three-bit source field picks event edges or system clock divided by 1..8192.
// - Run bit starts counting when one; zero clears and holds the counter.
// - Mode bit selects clear-on-match when zero, free-running PWM when one.
// - Outside PWM, set/clear pair: 00 keeps, 01 clears, 10 sets output flip-flop.
// - Set/clear bits are write-only and always read as zero.
// - Bit one enables toggle on match, or picks PWM active level (one is low).
// - Output-allow passes flip-flop state, or the PWM level in PWM, to the pin; zero holds the pin low.
// - In PWM, output sits at its inactive level while run is zero.
// - Mode, set/clear, level and allow settings reach the pin regardless of run.
// - Interval mode clears on match, continues, interrupting every compare plus one clocks.
module timer_event_counter_8bit import tec8_pkg::*; (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [15:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic event_input_pin,
	output logic timer_output_pin,
	output logic timer_output_oe,
	output logic match_irq
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Picks the count enable for the selected source; divided clocks use the free prescaler.
	function automatic logic source_tick(input logic [2:0] sel, input logic [12:0] pre,
			input logic rise, input logic fall);
		logic t;
		t = 1'b0;
		unique case (sel)
			SRC_EV_FALL: t = fall;
			SRC_EV_RISE: t = rise;
			SRC_DIV1: t = 1'b1;
			SRC_DIV2: t = (pre & MASK_DIV2) == MASK_DIV2;
			SRC_DIV4: t = (pre & MASK_DIV4) == MASK_DIV4;
			SRC_DIV64: t = (pre & MASK_DIV64) == MASK_DIV64;
			SRC_DIV256: t = (pre & MASK_DIV256) == MASK_DIV256;
			SRC_DIV8192: t = (pre & MASK_DIV8192) == MASK_DIV8192;
		endcase
		return t;
	endfunction

	// Read view of the mode register; set/clear bits always read back as zero.
	function automatic logic [7:0] mode_read(input mode_type m);
		logic [7:0] v;
		v = 8'h00;
		v[MODE_RUN_BIT] = m.run;
		v[MODE_PWM_BIT] = m.pwm;
		v[MODE_TOG_BIT] = m.tog_pol;
		v[MODE_ALLOW_BIT] = m.allow;
		return v;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	state_type st_q;
	state_type st_d;
	logic ev_rise;
	logic ev_fall;
	logic tick;
	logic pwm_on;

	// Edges come from the second and third stages only, so the metastable stage feeds nothing else.
	assign ev_rise = st_q.ev.sync & ~st_q.ev.prev;
	assign ev_fall = ~st_q.ev.sync & st_q.ev.prev;
	assign tick = source_tick(st_q.src, st_q.pre, ev_rise, ev_fall);

	// Next-state logic for the whole block.
	always_comb begin
		st_d = st_q;
		st_d.irq = 1'b0;
		st_d.ev.meta = event_input_pin;
		st_d.ev.sync = st_q.ev.meta;
		st_d.ev.prev = st_q.ev.sync;
		st_d.pre = PRESCALE_WIDTH'(st_q.pre + PRESCALE_STEP);

		// Counting; a stopped timer keeps the count at zero and reloads the PWM buffer.
		if (!st_q.mode.run) begin
			st_d.count = COUNT_ZERO;
			st_d.pwm_cmp = st_q.match;
			st_d.pwm_level = 1'b0;
		end else if (tick) begin
			if (!st_q.mode.pwm) begin
				if (st_q.count == st_q.match) begin
					st_d.count = COUNT_ZERO;
					st_d.irq = 1'b1;
					if (st_q.mode.tog_pol) begin
						st_d.out_ff = ~st_q.out_ff;
					end
				end else begin
					st_d.count = 8'(st_q.count + COUNT_STEP);
				end
			end else begin
				// The compare value is buffered at overflow so a mid-period rewrite shows next period.
				st_d.count = 8'(st_q.count + COUNT_STEP);
				if (st_q.count == COUNT_TOP) begin
					st_d.pwm_cmp = st_q.match;
					st_d.pwm_level = st_q.match != COUNT_ZERO;
				end else if (8'(st_q.count + COUNT_STEP) == st_q.pwm_cmp) begin
					st_d.pwm_level = 1'b0;
				end
			end
		end

		// Register writes; software set/clear beats a toggle in the same cycle.
		if (sfr_wr) begin
			unique case (sfr_addr)
				ADDR_SOURCE: st_d.src = sfr_wdata[SOURCE_WIDTH-1:0];
				ADDR_MATCH: st_d.match = sfr_wdata;
				ADDR_PORT_DIR: st_d.port_dir = sfr_wdata;
				ADDR_PORT_LATCH: st_d.port_latch = sfr_wdata;
				ADDR_MODE: begin
					st_d.mode.run = sfr_wdata[MODE_RUN_BIT];
					st_d.mode.pwm = sfr_wdata[MODE_PWM_BIT];
					st_d.mode.tog_pol = sfr_wdata[MODE_TOG_BIT];
					st_d.mode.allow = sfr_wdata[MODE_ALLOW_BIT];
					if (!sfr_wdata[MODE_PWM_BIT]) begin
						if ({sfr_wdata[MODE_SET_BIT], sfr_wdata[MODE_CLR_BIT]} == SETCLR_SET) begin
							st_d.out_ff = 1'b1;
						end else if ({sfr_wdata[MODE_SET_BIT], sfr_wdata[MODE_CLR_BIT]} == SETCLR_CLEAR) begin
							st_d.out_ff = 1'b0;
						end
					end
				end
				default: begin
				end
			endcase
		end

		// Read data; unmapped addresses and idle cycles return zero.
		st_d.rdata = 8'h00;
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_COUNT: st_d.rdata = st_q.count;
				ADDR_MATCH: st_d.rdata = st_q.match;
				ADDR_SOURCE: st_d.rdata = {5'h00, st_q.src};
				ADDR_MODE: st_d.rdata = mode_read(st_q.mode);
				ADDR_PORT_DIR: st_d.rdata = st_q.port_dir;
				ADDR_PORT_LATCH: st_d.rdata = st_q.port_latch;
				default: st_d.rdata = 8'h00;
			endcase
		end

		// The pin follows the new settings at once, running or not.
		pwm_on = st_d.mode.run & st_d.pwm_level;
		st_d.pin = st_d.mode.allow & (st_d.mode.pwm ? (pwm_on ^ st_d.mode.tog_pol) : st_d.out_ff);
		// Driver is on only while the shared pin is set as an output.
		st_d.oe = ~st_d.port_dir[PIN_DIR_BIT];
	end

	// State register.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= STATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign sfr_rdata = st_q.rdata;
	assign timer_output_pin = st_q.pin;
	assign timer_output_oe = st_q.oe;
	assign match_irq = st_q.irq;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	stop_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!st_q.mode.run |=> st_q.count == COUNT_ZERO)
		else $error("count not cleared while stopped");

	count_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.run && tick && (st_q.mode.pwm || st_q.count != st_q.match)
		|=> st_q.count == 8'($past(st_q.count) + COUNT_STEP))
		else $error("count did not advance by one");

	count_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.run && !tick |=> $stable(st_q.count))
		else $error("count moved without a tick");

	match_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.run && tick && !st_q.mode.pwm && st_q.count == st_q.match
		|=> st_q.count == COUNT_ZERO && match_irq)
		else $error("match did not clear count and interrupt");

	irq_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		match_irq |-> $past(st_q.mode.run && tick && !st_q.mode.pwm && st_q.count == st_q.match))
		else $error("interrupt without a match");

	pwm_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.run && st_q.mode.pwm && tick && st_q.count == COUNT_TOP && st_q.match != COUNT_ZERO
		|=> st_q.pwm_level)
		else $error("pwm output not active after overflow");

	pwm_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.pwm && !st_q.mode.run && st_q.mode.allow |-> timer_output_pin == st_q.mode.tog_pol)
		else $error("pwm output not inactive while stopped");

	allow_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!st_q.mode.allow |-> !timer_output_pin)
		else $error("pin not low with output disallowed");

	ff_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_wr && sfr_addr == ADDR_MODE && !sfr_wdata[MODE_PWM_BIT] && sfr_wdata[MODE_SET_BIT]
		&& !sfr_wdata[MODE_CLR_BIT] && sfr_wdata[MODE_ALLOW_BIT] |=> timer_output_pin)
		else $error("set request did not reach the pin");

	setclr_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_rd && sfr_addr == ADDR_MODE |=> sfr_rdata[MODE_SET_BIT:MODE_CLR_BIT] == 2'h0)
		else $error("set/clear bits read non-zero");

	toggle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.run && tick && !st_q.mode.pwm && st_q.mode.tog_pol && st_q.count == st_q.match && !sfr_wr
		|=> st_q.out_ff != $past(st_q.out_ff))
		else $error("output flip-flop did not toggle on match");

	// ------------------------------------------------------------
	// Assertions on the bus, the pin and the PWM path
	// ------------------------------------------------------------

	// The PWM level must drop at the tick that brings the count to the buffered compare value.
	pwm_fall_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.run && st_q.mode.pwm && tick && st_q.count != COUNT_TOP
		&& 8'(st_q.count + COUNT_STEP) == st_q.pwm_cmp |=> !st_q.pwm_level)
		else $error("pwm output not inactive at compare");

	// A compare value of zero must keep the PWM output inactive through the whole period.
	pwm_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.run && st_q.mode.pwm && tick && st_q.count == COUNT_TOP && st_q.match == COUNT_ZERO
		|=> !st_q.pwm_level)
		else $error("pwm output active with zero compare");

	// The match interrupt is a clear-mode event only.
	pwm_no_irq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.pwm |=> !match_irq)
		else $error("interrupt raised in pwm mode");

	// A stopped PWM timer must not hold an active level for the next start.
	level_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!st_q.mode.run |=> !st_q.pwm_level)
		else $error("pwm level kept while stopped");

	// In clear mode the pin shows the output flip-flop whenever output is allowed.
	clear_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!st_q.mode.pwm && st_q.mode.allow |-> timer_output_pin == st_q.out_ff)
		else $error("pin does not follow the output flip-flop");

	// In PWM mode the pin shows the level, inverted when active-low is chosen.
	pwm_pin_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		st_q.mode.pwm && st_q.mode.allow && st_q.mode.run |-> timer_output_pin == (st_q.pwm_level ^ st_q.mode.tog_pol))
		else $error("pwm pin level wrong");

	// A clear request outside PWM mode must reach the pin at once.
	ff_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_wr && sfr_addr == ADDR_MODE && !sfr_wdata[MODE_PWM_BIT] && !sfr_wdata[MODE_SET_BIT]
		&& sfr_wdata[MODE_CLR_BIT] |=> !timer_output_pin)
		else $error("clear request did not reach the pin");

	// The run bit follows the last mode write.
	run_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_wr && sfr_addr == ADDR_MODE |=> st_q.mode.run == $past(sfr_wdata[MODE_RUN_BIT]))
		else $error("run bit not taken from write");

	// The mode bit follows the last mode write.
	mode_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_wr && sfr_addr == ADDR_MODE |=> st_q.mode.pwm == $past(sfr_wdata[MODE_PWM_BIT]))
		else $error("mode bit not taken from write");

	// Any compare value is stored as written.
	match_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_wr && sfr_addr == ADDR_MATCH |=> st_q.match == $past(sfr_wdata))
		else $error("compare value not stored");

	// The compare value reads back one cycle after the strobe.
	match_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_rd && sfr_addr == ADDR_MATCH |=> sfr_rdata == $past(st_q.match))
		else $error("compare value read wrong");

	// The count reads back as it stood at the strobe.
	count_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_rd && sfr_addr == ADDR_COUNT |=> sfr_rdata == $past(st_q.count))
		else $error("count read wrong");

	// Only the three low source bits are kept.
	source_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_wr && sfr_addr == ADDR_SOURCE |=> st_q.src == $past(sfr_wdata[SOURCE_WIDTH-1:0]))
		else $error("source select not stored");

	// The upper source bits always read as zero.
	source_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_rd && sfr_addr == ADDR_SOURCE |=> sfr_rdata[7:SOURCE_WIDTH] == 5'h00)
		else $error("upper source bits read non-zero");

	// Read data stands one cycle only, so a stale value cannot be mistaken for a new read.
	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!sfr_rd |=> sfr_rdata == 8'h00)
		else $error("read data not zero when idle");

	// The pin driver follows the direction bit of the shared pin.
	oe_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		timer_output_oe == !st_q.port_dir[PIN_DIR_BIT])
		else $error("driver enable disagrees with direction");

	// A direction write switches the driver at once.
	dir_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		sfr_wr && sfr_addr == ADDR_PORT_DIR |=> timer_output_oe == !$past(sfr_wdata[PIN_DIR_BIT]))
		else $error("direction write not applied");

	// The prescaler runs free by one each clock; divided ticks depend on it.
	pre_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		1'b1 |=> st_q.pre == PRESCALE_WIDTH'($past(st_q.pre) + PRESCALE_STEP))
		else $error("prescaler did not step");

	// One rising edge of the event gives one single-cycle strobe.
	rise_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_rise |=> !ev_rise)
		else $error("rising edge strobe too long");

	// One falling edge of the event gives one single-cycle strobe.
	fall_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ev_fall |=> !ev_fall)
		else $error("falling edge strobe too long");

endmodule // timer_event_counter_8bit

// ==== tec8_far_side.sv ====
`timescale 1ns/100ps
// Event source and load on the shared timer pin.
module tec8_far_side #(
	parameter int HOLD = 4
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pulse_req,
	input wire logic timer_output_pin,
	input wire logic timer_output_oe,
	output logic event_input_pin
);
	logic src_q;
	int cnt_q;
	// ----------------------------------------
	// Pulse source
	// ----------------------------------------
	// Each request gives one pulse HOLD cycles wide, slow enough for the input synchroniser.
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			src_q <= 1'b0;
			cnt_q <= 0;
		end else if (pulse_req && cnt_q == 0) begin
			src_q <= 1'b1;
			cnt_q <= HOLD;
		end else if (cnt_q != 0) begin
			cnt_q <= cnt_q - 1;
			if (cnt_q == 1) begin
				src_q <= 1'b0;
			end
		end
	end
	// The wire shows the timer output while it drives, else the source.
	assign event_input_pin = timer_output_oe ? timer_output_pin : src_q;
endmodule // tec8_far_side

// ==== timer_event_counter_8bit_tb_top.sv ====
`timescale 1ns/100ps
module timer_event_counter_8bit_tb_top import tec8_pkg::*;;
	logic clk_sys, rst_n, sfr_wr, sfr_rd, pin, oe, irq, ev, pulse_req;
	logic [15:0] sfr_addr;
	logic [7:0] sfr_wdata, sfr_rdata;
	int errors, compares, cyc, irqs;
	timer_event_counter_8bit timer_event_counter_8bit_i(.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.event_input_pin(ev), .timer_output_pin(pin), .timer_output_oe(oe), .match_irq(irq));
	tec8_far_side tec8_far_side_i(.clk_sys(clk_sys), .rst_n(rst_n), .pulse_req(pulse_req),
		.timer_output_pin(pin), .timer_output_oe(oe), .event_input_pin(ev));
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// The slowest divider test needs about 17000 cycles, so this leaves ample margin.
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			results();
		end
	end
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk_sys);
		sfr_wr <= 1'b0;
		#1;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task chk1(input logic got, input logic exp);
		chk8({7'h00, got}, {7'h00, exp});
	endtask
	task chkn(input int got, input int exp);
		compares++;
		if (got != exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task rchk(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk_sys);
		sfr_rd <= 1'b0;
		#1 chk8(sfr_rdata, exp);
	endtask
	task wait_irq(output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			#1 n++;
		end while (irq !== 1'b1 && n < 20000);
	endtask
	task gap(output int g);
		wait_irq(g);
		wait_irq(g);
	endtask
	task width(input logic lvl, output int n);
		n = 0;
		while (pin === lvl && n < 1000) begin
			@(posedge clk_sys);
			#1 n++;
			if (irq === 1'b1) irqs++;
		end
	endtask
	task pulse();
		@(posedge clk_sys);
		pulse_req <= 1'b1;
		@(posedge clk_sys);
		pulse_req <= 1'b0;
		repeat (12) @(posedge clk_sys);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_reset();
		rchk(ADDR_COUNT, 8'h00);
		rchk(ADDR_MATCH, 8'h00);
		rchk(ADDR_PORT_DIR, 8'hff);
		rchk(ADDR_SOURCE, 8'h00);
		rchk(ADDR_MODE, 8'h00);
		rchk(16'hff00, 8'h00);
		chk1(oe, 1'b0);
		$display("reset test done");
	endtask
	task t_regs();
		wr(ADDR_MATCH, 8'hff);
		rchk(ADDR_MATCH, 8'hff);
		wr(ADDR_COUNT, 8'h55);
		rchk(ADDR_COUNT, 8'h00);
		wr(ADDR_SOURCE, 8'hff);
		rchk(ADDR_SOURCE, 8'h07);
		wr(ADDR_SOURCE, 8'h02);
		wr(ADDR_MODE, 8'h0a);
		rchk(ADDR_MODE, 8'h02);
		chk1(pin, 1'b0);
		$display("register test done");
	endtask
	task t_interval();
		int g;
		logic p0;
		wr(ADDR_PORT_DIR, 8'h7f);
		chk1(oe, 1'b1);
		wr(ADDR_MATCH, 8'h02);
		wr(ADDR_MODE, 8'h02);
		wr(ADDR_MODE, 8'h03);
		wr(ADDR_MODE, 8'h07);
		chk1(pin, 1'b0);
		wr(ADDR_MODE, 8'h0b);
		chk1(pin, 1'b1);
		wr(ADDR_MODE, 8'h8b);
		gap(g);
		chkn(g, 3);
		p0 = pin;
		wait_irq(g);
		chk1(pin, ~p0);
		wr(ADDR_MODE, 8'h0b);
		@(posedge clk_sys);
		rchk(ADDR_COUNT, 8'h00);
		$display("interval test done");
	endtask
	task t_presc();
		int per[6] = '{1, 2, 4, 64, 256, 8192};
		int g;
		wr(ADDR_MATCH, 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_SOURCE, 8'(i + 2));
			wr(ADDR_MODE, 8'h8b);
			gap(g);
			chkn(g, per[i]);
			wr(ADDR_MODE, 8'h0b);
		end
		$display("divider test done");
	endtask
	task t_event();
		wr(ADDR_PORT_DIR, 8'hff);
		chk1(oe, 1'b0);
		wr(ADDR_MATCH, 8'h03);
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_SOURCE, 8'(s));
			wr(ADDR_MODE, 8'h80);
			pulse();
			pulse();
			rchk(ADDR_COUNT, 8'h02);
			wr(ADDR_MODE, 8'h00);
		end
		$display("event test done");
	endtask
	task t_pwm();
		int hi, lo;
		wr(ADDR_PORT_DIR, 8'h7f);
		wr(ADDR_SOURCE, 8'h02);
		wr(ADDR_MATCH, 8'h40);
		wr(ADDR_MODE, 8'h40);
		wr(ADDR_MODE, 8'h41);
		chk1(pin, 1'b0);
		wr(ADDR_MODE, 8'hc1);
		irqs = 0;
		width(1'b0, lo);
		width(1'b1, hi);
		width(1'b0, lo);
		chkn(hi, 64);
		chkn(lo, 192);
		chkn(irqs, 0);
		wr(ADDR_MATCH, 8'h80);
		width(1'b1, hi);
		width(1'b0, lo);
		width(1'b1, hi);
		chkn(hi, 128);
		wr(ADDR_MODE, 8'h41);
		chk1(pin, 1'b0);
		wr(ADDR_MODE, 8'h43);
		chk1(pin, 1'b1);
		$display("pwm test done");
	endtask
	task results();
		$display("compares=%0d errors=%0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		sfr_wr = 1'b0;
		sfr_rd = 1'b0;
		sfr_addr = 16'h0000;
		sfr_wdata = 8'h00;
		pulse_req = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_regs();
		t_interval();
		t_presc();
		t_event();
		t_pwm();
		results();
	end
endmodule // timer_event_counter_8bit_tb_top
